// *** design/bus_ctl.sv ***
/*
 * utility and control line logic of one board on the shared backplane:
 * interrupt requests, size and direction lines, bus timing clock, fail,
 * shared reset and post-reset mode select. open-collector lines are
 * in / out / enable triples, enable low while the line is pulled low.
 * assumes the surrounding board gives local requests synchronous to clk.
 */
// How it works
// [R1] seven active-low request lines; level seven wins, levels served in descending order
// [R2] size select high for byte or word, low for longword; slave decodes it
// [R3] longword only when both ends and backplane have wide data option
// [R4] controller drives free-running 16 MHz timing clock independent of processors; the divider here gives well below 16 MHz
// [R5] any module pulls fail line low; low level means system failure
// [R6] module stays in reset while shared reset line is low; any may pull
// [R7] mode select lines sampled at reset release choose operating mode
// [R8] direction line high for read, low for write; slave sources or accepts
// [R9] reserved backplane lines are neither driven nor used
// [R10] reset, fail and request inputs synchronised before use
module bus_ctl (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // board configuration
   input  wire logic        sys_controller,   // this board is the system controller
   input  wire logic        wide_data_option, // this board implements 32-bit data
   input  wire logic        wide_backplane,   // backplane has the expanded data path
   input  wire logic        peer_wide,        // addressed slave implements 32-bit data
   // local master request side
   input  wire logic        mst_active,       // a master cycle is in progress
   input  wire logic        mst_read,         // 1 read, 0 write
   input  wire logic        mst_want_long,    // master asks for a longword cycle
   output      logic        long_granted,     // longword cycle allowed for this request
   // backplane size and direction, master drive
   output      logic        long_transfer_select_o,
   output      logic        long_transfer_select_oe_b,
   output      logic        direction_o,
   output      logic        direction_oe_b,
   // backplane size and direction, slave view
   input  wire logic        long_transfer_select_i,
   input  wire logic        direction_i,
   input  wire logic        slv_strobe0_b,
   input  wire logic        slv_strobe1_b,
   output      logic [2:0]  slv_width,
   output      logic        slv_source_data,
   // interrupt requests
   input  wire logic [6:0]  local_irq,         // bit n asks for level n+1
   input  wire logic [6:0]  interrupt_request_lines_i,
   output      logic [6:0]  interrupt_request_lines_o,
   output      logic [6:0]  interrupt_request_lines_oe_b,
   output      logic [2:0]  irq_level,         // highest pending level, 0 none
   // bus timing clock
   output      logic        bus_timing_clock_o,
   output      logic        bus_timing_clock_oe_b,
   // system failure
   input  wire logic        local_fail,
   input  wire logic        system_failure_line_i,
   output      logic        system_failure_line_o,
   output      logic        system_failure_line_oe_b,
   output      logic        system_failed,
   // shared reset
   input  wire logic        local_reset_req,
   input  wire logic        shared_reset_line_i,
   output      logic        shared_reset_line_o,
   output      logic        shared_reset_line_oe_b,
   output      logic        in_reset,
   // mode select
   input  wire logic [1:0]  post_reset_mode_select_i,
   output      logic [1:0]  post_reset_mode_select_o,
   output      logic [1:0]  post_reset_mode_select_oe_b,
   output      logic [1:0]  op_mode
);
   logic [6:0] irq_s;
   logic       fail_s;
   logic       rst_s;
   logic       rst_prev_q;
   logic [1:0] mode_q;
   logic [2:0] level_q;
   logic [15:0] phase_q;
   logic       bclk_q;
   logic       long_q;
   logic       dir_q;
   logic       drive_q;
   logic [2:0] level_d;

   // request, fail and reset lines from other boards cross into clk first
   sync2 #(.W(7), .RST_VAL(7'h7f)) u_irq_sync (                  // see [R10]
      .clk(clk), .rst_b(rst_b), .d(interrupt_request_lines_i), .q(irq_s));
   sync2 #(.W(1), .RST_VAL(1'b1)) u_fail_sync (                  // see [R10]
      .clk(clk), .rst_b(rst_b), .d(system_failure_line_i), .q(fail_s));
   sync2 #(.W(1), .RST_VAL(1'b0)) u_rst_sync (                   // see [R10]
      .clk(clk), .rst_b(rst_b), .d(shared_reset_line_i), .q(rst_s));

   // open-collector pulls: output is always low, enable low while pulling
   assign interrupt_request_lines_o   = 7'h00;
   assign interrupt_request_lines_oe_b = ~local_irq;             // see [R1]
   assign system_failure_line_o        = 1'b0;
   assign system_failure_line_oe_b     = ~local_fail;            // see [R5]
   assign shared_reset_line_o          = 1'b0;
   assign shared_reset_line_oe_b       = ~local_reset_req;       // see [R6]
   // mode select lines are only read here; reserved lines have no port at all
   assign post_reset_mode_select_o     = 2'h0;
   assign post_reset_mode_select_oe_b  = 2'h3;                   // see [R9]

   assign system_failed = ~fail_s;                               // see [R5]
   assign in_reset      = ~rst_s;                                // see [R6]
   assign op_mode       = mode_q;
   assign irq_level     = level_q;

   // priority encoder: highest requesting level wins
   always_comb begin
      level_d = bus_ctl_pkg::LEVEL_NONE;
      for (int i = 0; i < 7; i++) begin
         if (!irq_s[i]) begin
            level_d = 3'(i + 1);                                 // see [R1]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_q <= bus_ctl_pkg::LEVEL_NONE;
      end else if (!rst_s) begin
         level_q <= bus_ctl_pkg::LEVEL_NONE;                     // see [R6]
      end else begin
         level_q <= level_d;
      end
   end

   // mode select caught on the release edge of the shared reset line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_prev_q <= 1'b0;
         mode_q     <= bus_ctl_pkg::MODE_RESET;
      end else begin
         rst_prev_q <= rst_s;
         if (rst_s && !rst_prev_q) begin
            mode_q <= ~post_reset_mode_select_i;                 // see [R7]
         end
      end
   end

   // fractional divider: the 16-bit phase sum wraps, so it toggles on about five of six core edges, well below 16 MHz
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= bus_ctl_pkg::PHASE_RESET;
         bclk_q  <= 1'b0;
      end else if (phase_q + bus_ctl_pkg::PHASE_STEP >= bus_ctl_pkg::PHASE_MOD) begin
         phase_q <= 16'(phase_q + bus_ctl_pkg::PHASE_STEP - bus_ctl_pkg::PHASE_MOD);
         bclk_q  <= ~bclk_q;                                     // see [R4]
      end else begin
         phase_q <= 16'(phase_q + bus_ctl_pkg::PHASE_STEP);
      end
   end
   // runs even through shared reset: independent of any processor
   assign bus_timing_clock_o    = bclk_q;
   assign bus_timing_clock_oe_b = ~sys_controller;               // see [R4]

   // longword permission
   assign long_granted = mst_want_long & wide_data_option & peer_wide
                         & wide_backplane;                       // see [R3]

   // master drive of size and direction lines, registered
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         long_q  <= 1'b1;
         dir_q   <= 1'b1;
         drive_q <= 1'b0;
      end else begin
         drive_q <= mst_active & rst_s;
         long_q  <= ~long_granted;                               // see [R2]
         dir_q   <= mst_read;                                    // see [R8]
      end
   end
   assign long_transfer_select_o    = long_q;
   assign long_transfer_select_oe_b = ~drive_q;
   assign direction_o               = dir_q;
   assign direction_oe_b            = ~drive_q;

   // slave decode of width and data direction, registered so the outputs are clean
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slv_width       <= bus_ctl_pkg::XFER_BYTE;
         slv_source_data <= 1'b0;
      end else begin
         if (!long_transfer_select_i && wide_data_option) begin
            slv_width <= bus_ctl_pkg::XFER_LONG;                 // see [R2]
         end else if (!slv_strobe0_b && !slv_strobe1_b) begin
            slv_width <= bus_ctl_pkg::XFER_WORD;
         end else begin
            slv_width <= bus_ctl_pkg::XFER_BYTE;
         end
         slv_source_data <= direction_i;                         // see [R8]
      end
   end

   // longword only on a wide configuration
   long_cfg_a: assert property (@(posedge clk) disable iff (!rst_b) // see [R3]
      (drive_q && !long_q) |-> $past(wide_backplane && wide_data_option))
      else $error("longword driven without wide path");
   // highest level chosen
   irq_prio_a: assert property (@(posedge clk) disable iff (!rst_b) // see [R1]
      (rst_s && !irq_s[6]) |=> (level_q == 3'h7))
      else $error("level seven not chosen");
   // fail line mirrored two edges later
   fail_sync_a: assert property (@(posedge clk) disable iff (!rst_b) // see [R5]
      !system_failure_line_i [*3] |-> system_failed)
      else $error("system failure not flagged");
   // reset holds level cleared
   reset_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // see [R6]
      in_reset |=> (level_q == 3'h0))
      else $error("level not cleared in reset");
   // mode follows select at release
   mode_cap_a: assert property (@(posedge clk) disable iff (!rst_b) // see [R7]
      (rst_s && !rst_prev_q) |=> (mode_q == ~$past(post_reset_mode_select_i)))
      else $error("mode not captured at release");
   // direction follows master read
   dir_drive_a: assert property (@(posedge clk) disable iff (!rst_b) // see [R8]
      mst_active |=> (direction_o == $past(mst_read)))
      else $error("direction line wrong");
   // timing clock toggles within two edges
   clk_run_a: assert property (@(posedge clk) disable iff (!rst_b) // see [R4]
      1'b1 |-> ##[1:2] $changed(bclk_q))
      else $error("timing clock stalled");
   // mode select lines never driven
   no_drive_a: assert property (@(posedge clk) disable iff (!rst_b) // see [R9]
      post_reset_mode_select_oe_b == 2'h3)
      else $error("select lines driven");
endmodule : bus_ctl

// *** design/bus_ctl_pkg.sv ***
/*
 * constants for the backplane utility and control line block: widths,
 * transfer width encodings, reset values and the bus timing clock divider.
 * assumes a single 25 MHz core clock and active-low async reset.
 */
package bus_ctl_pkg;
   localparam int unsigned IRQ_LEVELS      = 7;
   localparam int unsigned MODE_W          = 2;
   // time constants: core period and bus timing clock frequency
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned CLK_FREQ_KHZ    = 25000;
   localparam int unsigned BUS_CLK_FREQ_KHZ = 16000;
   // accumulator step for a fractional divider: phase advances by 32/25 per edge
   localparam logic [15:0] PHASE_STEP      = 16'(BUS_CLK_FREQ_KHZ * 2);
   localparam logic [15:0] PHASE_MOD       = 16'(CLK_FREQ_KHZ);
   localparam logic [15:0] PHASE_RESET     = 16'h0000;
   // reset values
   localparam logic [1:0]  MODE_RESET      = 2'h0;
   localparam logic [2:0]  LEVEL_NONE      = 3'h0;

   // transfer width decoded from the size line and data strobes
   typedef enum logic [2:0] {
      XFER_BYTE = 3'b001,
      XFER_WORD = 3'b010,
      XFER_LONG = 3'b100
   } xfer_t;
endpackage : bus_ctl_pkg

// *** design/sync2.sv ***
/*
 * two flop synchroniser for a bundle of levels.
 * assumes the reset value is given by the caller as a constant.
 */
module sync2 #(
   parameter int unsigned W        = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // levels
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage is read only by the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : sync2

// *** verif/backplane_peer.sv ***
/*
 * other boards on the backplane: pull-up open-collector lines that any
 * board may pull low. assumes oe_b low means the board pulls its line.
 */
module backplane_peer (
   // board side enables: [6:0] requests, [7] fail, [8] reset, [10:9] mode
   input  wire logic [10:0] dut_oe_b,
   // pulls by the other boards, high pulls low
   input  wire logic [10:0] peer_pull,
   // resolved line levels
   output      logic [10:0] line
);
   timeunit 1ns;
   timeprecision 1ps;
   // wired and with pull-up, low when any party pulls
   assign line = dut_oe_b & ~peer_pull;
endmodule : backplane_peer

// *** verif/tb_top.sv ***
/*
 * self-checking bench for the backplane control line block.
 * assumes the peer model resolves the open-collector lines.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, sc, wdo, wbp, pw, act, rd, wl, lg, lsel_o, lsel_oe_b;
   logic        dir_o, dir_oe_b, lsel_i, dir_i, s0_b, s1_b, src, bclk, bclk_oe_b;
   logic        lfail, f_o, f_oe_b, failed, lrst, r_o, r_oe_b, in_rst;
   logic [2:0]  width, lvl;
   logic [6:0]  lirq, irq_o, irq_oe_b;
   logic [1:0]  m_o, m_oe_b, mode;
   logic [10:0] pull, line;
   int          bad_count, check_count, i, tg;
   logic [6:0]  irq_tab [4] = '{7'h40, 7'h41, 7'h01, 7'h00};

   bus_ctl bus_ctl_i (.clk(clk), .rst_b(rst_b), .sys_controller(sc), .wide_data_option(wdo),
      .wide_backplane(wbp), .peer_wide(pw), .mst_active(act), .mst_read(rd),
      .mst_want_long(wl), .long_granted(lg), .long_transfer_select_o(lsel_o),
      .long_transfer_select_oe_b(lsel_oe_b), .direction_o(dir_o), .direction_oe_b(dir_oe_b),
      .long_transfer_select_i(lsel_i), .direction_i(dir_i), .slv_strobe0_b(s0_b),
      .slv_strobe1_b(s1_b), .slv_width(width), .slv_source_data(src), .local_irq(lirq),
      .interrupt_request_lines_i(line[6:0]), .interrupt_request_lines_o(irq_o),
      .interrupt_request_lines_oe_b(irq_oe_b), .irq_level(lvl), .bus_timing_clock_o(bclk),
      .bus_timing_clock_oe_b(bclk_oe_b), .local_fail(lfail), .system_failure_line_i(line[7]),
      .system_failure_line_o(f_o), .system_failure_line_oe_b(f_oe_b), .system_failed(failed),
      .local_reset_req(lrst), .shared_reset_line_i(line[8]), .shared_reset_line_o(r_o),
      .shared_reset_line_oe_b(r_oe_b), .in_reset(in_rst), .post_reset_mode_select_i(line[10:9]),
      .post_reset_mode_select_o(m_o), .post_reset_mode_select_oe_b(m_oe_b), .op_mode(mode));
   backplane_peer backplane_peer_i (.dut_oe_b({m_oe_b, r_oe_b, f_oe_b, irq_oe_b}),
      .peer_pull(pull), .line(line));

   // 25 MHz core clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // compare and count
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (e !== s) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // wait edges, then move off the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // highest requested level, 0 for none
   function automatic logic [2:0] exp_lvl(input logic [6:0] r);
      for (int k = 6; k >= 0; k--) if (r[k]) return 3'(k + 1);
      return 3'h0;
   endfunction : exp_lvl

   // slave width decode
   function automatic logic [2:0] exp_w(input logic l, w, a, b);
      if (!l && w) return 3'b100;
      if (!a && !b) return 3'b010;
      return 3'b001;
   endfunction : exp_w

   // verdict and end of run
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // watchdog
   initial begin
      #200000;
      bad_count++;
      close_out();
   end

   // main sequence
   initial begin
      {sc, wdo, wbp, pw, act, rd, wl, lsel_i, dir_i, lfail, lrst} = '0;
      {s0_b, s1_b, lirq, pull, rst_b, tg} = '0;
      s0_b = 1'b1;
      s1_b = 1'b1;
      i = $urandom(25072);
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      step(4);
      // reset line pulled by a peer, mode taken at release
      for (i = 0; i < 4; i++) begin
         pull[10:8] = {i[1:0], 1'b1};
         step(3);
         chk("in_reset", 1, in_rst);
         pull[8] = 1'b0;
         step(4);
         chk("in_reset", 0, in_rst);
         chk("op_mode", i[1:0], mode);
      end
      // every size and direction combination as master
      for (i = 0; i < 32; i++) begin
         {wl, wdo, pw, wbp, rd} = i[4:0];
         act = 1'b1;
         step(2);
         chk("long_granted", wl & wdo & pw & wbp, lg);
         chk("size_line", !(wl & wdo & pw & wbp), lsel_o);
         chk("size_oe_b", 0, lsel_oe_b);
         chk("direction", rd, dir_o);
         chk("dir_oe_b", 0, dir_oe_b);
      end
      act = 1'b0;
      step(2);
      chk("dir_oe_b", 1, dir_oe_b);
      // slave view, random levels, decode registered on the next edge
      for (i = 0; i < 40; i++) begin
         {lsel_i, dir_i, s0_b, s1_b, wdo} = 5'($urandom);
         step(1);
         chk("slv_width", exp_w(lsel_i, wdo, s0_b, s1_b), width);
         chk("slv_source", dir_i, src);
      end
      // requests, corner table then random
      for (i = 0; i < 24; i++) begin
         pull[6:0] = (i < 4) ? irq_tab[i] : 7'($urandom);
         lirq = (i < 4) ? 7'h00 : 7'($urandom);
         step(4);
         chk("irq_oe_b", 7'(~lirq), irq_oe_b);
         chk("irq_level", exp_lvl(pull[6:0] | lirq), lvl);
      end
      {pull[6:0], lirq} = '0;
      // failure line pulled locally, then by a peer
      lfail = 1'b1;
      step(4);
      chk("fail_oe_b", 0, f_oe_b);
      chk("failed", 1, failed);
      {lfail, pull[7]} = 2'b01;
      step(4);
      chk("failed", 1, failed);
      pull[7] = 1'b0;
      step(4);
      chk("failed", 0, failed);
      // local reset request pulls the shared line and holds master drive off
      lrst = 1'b1;
      act = 1'b1;
      step(4);
      chk("reset_oe_b", 0, r_oe_b);
      chk("in_reset", 1, in_rst);
      chk("size_oe_b", 1, lsel_oe_b);
      {lrst, act} = 2'b00;
      step(4);
      // timing clock only from the controller, running
      chk("bclk_oe_b", 1, bclk_oe_b);
      sc = 1'b1;
      step(2);
      for (i = 0; i < 100; i++) begin
         if (bclk !== 1'b0) tg++;
         step(1);
      end
      chk("bclk_oe_b", 0, bclk_oe_b);
      chk("bclk_runs", 1, 8'(tg > 0 && tg < 100));
      // open-collector data outputs stay low; select lines are never pulled
      chk("irq_o", 0, irq_o);
      chk("fail_o", 0, f_o);
      chk("reset_o", 0, r_o);
      chk("mode_o", 0, m_o);
      chk("mode_oe_b", 3, m_oe_b);
      close_out();
   end
endmodule : tb_top
